// ### bench/field_bus_peer.sv
// Purpose: bus neighbour flagging a silent node that takes the token
// Assumes: one decoder on the bus
// Notes: flag is registered
`timescale 1ns/1ps
module field_bus_peer (
  // clock
  input wire logic mclk_in,
  // decoder status
  input wire logic master_in,
  input wire logic silent_in,
  // observation
  output logic collide_out
);
  always_ff @(posedge mclk_in) collide_out <= master_in & silent_in;
endmodule : field_bus_peer

// ### bench/strap_sva.sv
// Purpose: port checks of the strap decoder
// Assumes: outputs settle once per reset
// Notes: bound to every decoder
`timescale 1ns/1ps
module strap_sva (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic latched_out,
  input wire logic [6:0] node_addr_out,
  input wire logic [7:0] n2_addr_out,
  input wire logic wireless_mode_out,
  input wire logic addr_valid_out,
  input wire logic token_master_out,
  input wire logic bus_silent_out,
  input wire logic bus_disrupt_risk_out,
  input wire strap_pkg::role_t role_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_held; latched_out [*3]; endsequence
  property p_hold; s_held |-> $stable(role_out) && $stable(node_addr_out);
  endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_latch; latched_out |=> latched_out; endproperty
  a_latch: assert property (p_latch) else $error("latch lost");
  property p_quiet; !latched_out |-> bus_silent_out; endproperty
  a_quiet: assert property (p_quiet) else $error("early talk");
  property p_risk; bus_disrupt_risk_out |-> wireless_mode_out
    && role_out == strap_pkg::ROLE_WIRELESS_MASTER; endproperty
  a_risk: assert property (p_risk) else $error("bad risk");
  property p_tok; token_master_out |-> addr_valid_out && !bus_silent_out;
  endproperty
  a_tok: assert property (p_tok) else $error("bad master");
  property p_wm; role_out == strap_pkg::ROLE_WIRED_MASTER |->
    node_addr_out >= 7'h04 && !wireless_mode_out && token_master_out;
  endproperty
  a_wm: assert property (p_wm) else $error("bad wired");
  property p_sl; role_out == strap_pkg::ROLE_WIRED_SLAVE |->
    node_addr_out < 7'h04 && bus_silent_out && !token_master_out; endproperty
  a_sl: assert property (p_sl) else $error("bad slave");
  property p_n2; role_out == strap_pkg::ROLE_N2_NODE |->
    n2_addr_out != 8'h00 && n2_addr_out[6:0] == node_addr_out; endproperty
  a_n2: assert property (p_n2) else $error("bad n2");
endmodule : strap_sva
bind address_strap_decode strap_sva u_sva (.mclk_in(mclk_in),
  .rst_in(rst_in), .latched_out(latched_out), .role_out(role_out),
  .node_addr_out(node_addr_out), .n2_addr_out(n2_addr_out),
  .wireless_mode_out(wireless_mode_out), .addr_valid_out(addr_valid_out),
  .token_master_out(token_master_out), .bus_silent_out(bus_silent_out),
  .bus_disrupt_risk_out(bus_disrupt_risk_out));

// ### bench/tb_top.sv
// Purpose: self-checking bench of the strap decoder
// Assumes: pins steady through each reset
// Notes: boundary straps, then random ones
`timescale 1ns/1ps
module tb_top;
  logic mclk_in = 1'b0, rst_in = 1'b1, n2_mode_in = 1'b0, collide;
  logic [7:0] strap_in = 8'h00, s;
  logic latched_out, wireless_mode_out, addr_valid_out, token_master_out;
  logic bus_silent_out, bus_disrupt_risk_out;
  logic [6:0] node_addr_out;
  logic [7:0] n2_addr_out;
  strap_pkg::role_t role_out;
  logic [7:0] tbl [9] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h7f, 8'h80, 8'h83,
    8'h84, 8'hff};
  logic [24:0] act;
  int num_errors = 0, check_count = 0;
  assign act = {collide, latched_out, node_addr_out, n2_addr_out,
    wireless_mode_out, addr_valid_out, token_master_out, bus_silent_out,
    bus_disrupt_risk_out, role_out};
  address_strap_decode u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .strap_in(strap_in), .n2_mode_in(n2_mode_in), .latched_out(latched_out),
    .node_addr_out(node_addr_out), .n2_addr_out(n2_addr_out),
    .wireless_mode_out(wireless_mode_out), .addr_valid_out(addr_valid_out),
    .token_master_out(token_master_out), .bus_silent_out(bus_silent_out),
    .bus_disrupt_risk_out(bus_disrupt_risk_out), .role_out(role_out));
  field_bus_peer u_peer (.mclk_in(mclk_in), .master_in(token_master_out),
    .silent_in(bus_silent_out), .collide_out(collide));
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  function automatic logic [24:0] model(input logic [7:0] s, input logic n);
    logic v;
    strap_pkg::role_t r;
    v = n ? s != 8'h00 : s[6:0] >= 7'h04;
    if (n) r = v ? strap_pkg::ROLE_N2_NODE : strap_pkg::ROLE_N2_INVALID;
    else if (s[7]) r = v ? strap_pkg::ROLE_WIRELESS_MASTER
      : strap_pkg::ROLE_WIRED_SLAVE;
    else if (s[6:0] == 7'h00) r = strap_pkg::ROLE_RSV_SUPERVISOR;
    else r = v ? strap_pkg::ROLE_WIRED_MASTER : strap_pkg::ROLE_RSV_PERIPHERAL;
    return {2'b01, s[6:0], n ? s : 8'h00, s[7] & !n, v, v & !n, !v,
      s[7] & v & !n, r};
  endfunction : model
  task automatic cmp(input logic [24:0] e);
    check_count++;
    if (act !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, act, e);
    end
  endtask : cmp
  task automatic run(input logic [7:0] v, input logic n);
    @(posedge mclk_in);
    #1 rst_in = 1'b1;
    strap_in = v;
    n2_mode_in = n;
    repeat (5) @(posedge mclk_in);
    #1 cmp(25'h0000010);
    rst_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    #1 cmp(model(v, n));
    strap_in = ~v;
    n2_mode_in = ~n;
    repeat (4) @(posedge mclk_in);
    #1 cmp(model(v, n));
  endtask : run
  initial begin
    void'($urandom(32'ha705));
    for (int i = 0; i < 30; i++) begin
      s = i < 18 ? tbl[i / 2] : 8'($urandom);
      run(s, i[0]);
    end
    end_sim;
  end
  initial begin
    #4000;
    num_errors++;
    end_sim;
  end
endmodule : tb_top

// ### verilog/address_strap_decode.sv
// Purpose: latch the address/mode strap once after reset and decode role
// Assumes: strap pins are asynchronous and static while running
//   pins stay steady from reset release until latched_out rises
//   a power cycle reaches this block as a pulse on rst_in
// Notes: the n2 select is synchronised and latched with the strap; latched values hold until reset
//   pin changes after capture are ignored without any indication
`timescale 1ns/1ps
module address_strap_decode (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // strap pins and protocol select
  input wire logic [7:0] strap_in,
  input wire logic n2_mode_in,
  // decoded configuration
  output logic latched_out,
  output logic [6:0] node_addr_out,
  output logic [7:0] n2_addr_out,
  output logic wireless_mode_out,
  output logic addr_valid_out,
  output logic token_master_out,
  output logic bus_silent_out,
  output logic bus_disrupt_risk_out,
  output strap_pkg::role_t role_out
);
  // ****************************************************************
  // synchronise pins
  // ****************************************************************
  logic [8:0] pins_sync;
  logic [7:0] strap_sync;
  logic n2_sync;

  sync2 #(
    .W(9)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .d_in({n2_mode_in, strap_in}),
    .q_out(pins_sync)
  );

  // the n2 select rides on the top synchroniser bit
  assign strap_sync = pins_sync[strap_pkg::STRAP_W-1:0];
  assign n2_sync = pins_sync[strap_pkg::STRAP_W];

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] settle;
    logic latched;
    logic [7:0] strap;
    logic n2;
    logic [6:0] node_addr;
    logic [7:0] n2_addr;
    logic wireless;
    logic valid;
    logic master;
    logic silent;
    logic disrupt;
    strap_pkg::role_t role;
  } dec_state_t;

  dec_state_t st;
  dec_state_t next_st;

  // ****************************************************************
  // capture and decode
  // ****************************************************************
  always_comb begin
    logic [6:0] a;
    logic m;
    logic in_range;
    strap_pkg::role_t role;
    a = '0;
    m = 1'b0;
    in_range = 1'b0;
    role = strap_pkg::ROLE_NONE;
    next_st = st;

    // wait for the synchroniser to fill before capturing
    if (!st.latched) begin
      if (st.settle != strap_pkg::SETTLE_LAST) begin
        next_st.settle = st.settle + 2'h1;
      end else begin
        next_st.latched = 1'b1;
        next_st.strap = strap_sync;
        next_st.n2 = n2_sync;
      end
    end

    a = st.strap[strap_pkg::ADDR_W-1:0];
    m = st.strap[strap_pkg::MODE_BIT];
    in_range = (a >= strap_pkg::ADDR_FIRST_MASTER) &&
               (a <= strap_pkg::ADDR_MAX);

    // classify the latched strap into exactly one role
    if (st.latched) begin
      if (st.n2) begin
        if (st.strap >= strap_pkg::N2_ADDR_MIN &&
            st.strap <= strap_pkg::N2_ADDR_MAX) begin
          role = strap_pkg::ROLE_N2_NODE;
        end else begin
          role = strap_pkg::ROLE_N2_INVALID;
        end
      end else if (!m) begin
        if (a == strap_pkg::ADDR_SUPERVISOR) begin
          role = strap_pkg::ROLE_RSV_SUPERVISOR;
        end else if (!in_range) begin
          role = strap_pkg::ROLE_RSV_PERIPHERAL;
        end else begin
          role = strap_pkg::ROLE_WIRED_MASTER;
        end
      end else begin
        if (!in_range) begin
          role = strap_pkg::ROLE_WIRED_SLAVE;
        end else begin
          role = strap_pkg::ROLE_WIRELESS_MASTER;
        end
      end
    end

    // bus behaviour follows from the role alone; quiet unless a master or an n2 node
    next_st.role = role;
    next_st.node_addr = a;
    next_st.n2_addr = '0;
    next_st.wireless = 1'b0;
    next_st.valid = 1'b0;
    next_st.master = 1'b0;
    next_st.silent = 1'b1;
    next_st.disrupt = 1'b0;
    case (role)
      strap_pkg::ROLE_N2_NODE: begin
        // all eight positions weigh in as address bits
        next_st.n2_addr = st.strap;
        next_st.valid = 1'b1;
        next_st.silent = 1'b0;
      end
      strap_pkg::ROLE_N2_INVALID: begin
        // n2 address 0 is shown but never used on the bus
        next_st.n2_addr = st.strap;
      end
      strap_pkg::ROLE_RSV_SUPERVISOR: begin
        next_st.silent = 1'b1;
      end
      strap_pkg::ROLE_RSV_PERIPHERAL: begin
        next_st.silent = 1'b1;
      end
      strap_pkg::ROLE_WIRED_MASTER: begin
        next_st.valid = 1'b1;
        next_st.master = 1'b1;
        next_st.silent = 1'b0;
      end
      strap_pkg::ROLE_WIRED_SLAVE: begin
        // no token passing and no drive on a wired bus
        next_st.wireless = 1'b1;
        next_st.silent = 1'b1;
      end
      strap_pkg::ROLE_WIRELESS_MASTER: begin
        next_st.wireless = 1'b1;
        next_st.valid = 1'b1;
        next_st.master = 1'b1;
        next_st.silent = 1'b0;
        // a wired bus stalls while this node is attached
        next_st.disrupt = 1'b1;
      end
      default: begin
        // not yet latched: keep the quiet defaults
        next_st.silent = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // register
  // ****************************************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '{
        settle: 2'h0,
        latched: 1'b0,
        strap: strap_pkg::STRAP_RST,
        n2: 1'b0,
        node_addr: 7'h00,
        n2_addr: 8'h00,
        wireless: 1'b0,
        valid: 1'b0,
        master: 1'b0,
        silent: 1'b1,
        disrupt: 1'b0,
        role: strap_pkg::ROLE_NONE
      };
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign latched_out = st.latched;
  assign node_addr_out = st.node_addr;
  assign n2_addr_out = st.n2_addr;
  assign wireless_mode_out = st.wireless;
  assign addr_valid_out = st.valid;
  assign token_master_out = st.master;
  assign bus_silent_out = st.silent;
  assign bus_disrupt_risk_out = st.disrupt;
  assign role_out = st.role;
endmodule : address_strap_decode

// ### verilog/strap_pkg.sv
// Purpose: constants and types for the address strap decoder
// Assumes: eight strap positions, weights 128 down to 1
// Notes: one role per decoded strap setting
package strap_pkg;
  // ****************************************************************
  // strap layout
  // ****************************************************************
  localparam int STRAP_W = 8;
  localparam int ADDR_W = 7;
  localparam int MODE_BIT = 7;
  localparam logic [7:0] STRAP_RST = 8'h00;
  localparam logic [6:0] ADDR_FIRST_MASTER = 7'h04;
  localparam logic [6:0] ADDR_MAX = 7'h7f;
  localparam logic [6:0] ADDR_SUPERVISOR = 7'h00;
  localparam logic [7:0] N2_ADDR_MIN = 8'h01;
  localparam logic [7:0] N2_ADDR_MAX = 8'hff;
  // last settle count before the strap is captured
  localparam logic [1:0] SETTLE_LAST = 2'h3;

  // ****************************************************************
  // roles
  // ****************************************************************
  typedef enum logic [2:0] {
    ROLE_NONE,
    ROLE_RSV_SUPERVISOR,
    ROLE_RSV_PERIPHERAL,
    ROLE_WIRED_MASTER,
    ROLE_WIRED_SLAVE,
    ROLE_WIRELESS_MASTER,
    ROLE_N2_NODE,
    ROLE_N2_INVALID
  } role_t;
endpackage : strap_pkg

// ### verilog/sync2.sv
// Purpose: two flip-flop synchroniser for a bus of levels
// Assumes: inputs are quasi-static pins
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.s2;
endmodule : sync2
